// ### rcfg_defs.svh
// register offsets, field positions, reset values and timing counts
// for the receiver configuration bank; included by rcfg_regs, rcfg_squelch and the bench.
`ifndef RCFG_DEFS_SVH
`define RCFG_DEFS_SVH

// register indices; byte address is four times the index
`define RCFG_IDX_FILT_CH      6'h0B
`define RCFG_IDX_DEMOD_GAIN   6'h0C
`define RCFG_IDX_SQ_TIME      6'h10
`define RCFG_IDX_STATUS       6'h11

`define RCFG_RST_FILT_CH      8'h00
`define RCFG_RST_DEMOD_GAIN   8'h2C
`define RCFG_RST_SQ_TIME      8'h00

// first receiver register fields
`define RCFG_RX_CHANNEL_CHOICE_BIT       7
`define RCFG_LP_HI            6
`define RCFG_LP_LO            4
`define RCFG_ZA_BIT           3
`define RCFG_ZB_BIT           2
`define RCFG_ZC_BIT           1
`define RCFG_ZD_BIT           0

// second receiver register fields
`define RCFG_DEMOD_BIT        7
`define RCFG_AMD_BIT          6
`define RCFG_SQ_DYN_BIT       5
`define RCFG_SQ_RATIO_BIT     4
`define RCFG_AGC_EN_BIT       3
`define RCFG_AGC_MODE_BIT     2
`define RCFG_AGC_ALG_BIT      1
`define RCFG_AGC_RATIO_BIT    0

// status register fields
`define RCFG_ST_SQ_BIT        0
`define RCFG_ST_AGC_BIT       1
`define RCFG_ST_FRAME_BIT     2
`define RCFG_ST_IQ_ERR_BIT    3

`define RCFG_AGC_PULSES       8
`define RCFG_CLK_MHZ          200
`define RCFG_SQ_DELAY_US_X100 1888
`define RCFG_SQ_DELAY_CYC     ((`RCFG_SQ_DELAY_US_X100 * `RCFG_CLK_MHZ + 99) / 100)

`endif

// ### rcfg_pkg.sv
// types shared by the receiver configuration bank
// assumes nothing beyond a SystemVerilog compiler
package rcfg_pkg;
    // gray along idle -> wait -> active
    typedef enum logic [1:0] {
        RCFG_SQ_IDLE = 2'b00,
        RCFG_SQ_WAIT = 2'b01,
        RCFG_SQ_ACT  = 2'b11
    } rcfg_sq_state_t;
endpackage : rcfg_pkg

// ### rcfg_regs.sv
// receiver configuration bank: two receiver registers, a squelch time
// register and a status register behind classic wishbone.
// assumes all strobes come from logic on clk_i; single clock domain.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rcfg_defs.svh"
module rcfg_regs
    import rcfg_pkg::*;
#(
    parameter int SQ_DELAY_CYC = `RCFG_SQ_DELAY_CYC,
    parameter int AGC_PULSES   = `RCFG_AGC_PULSES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic      [31:0] wb_dat_o,
    input  wire logic        rx_single_ch_i,
    input  wire logic        rx_manual_sel_i,
    input  wire logic        rx_auto_ch_i,
    input  wire logic        tx_end_i,
    input  wire logic        rx_active_i,
    input  wire logic        subcarrier_pulse_i,
    input  wire logic [7:0]  mrt_count_i,
    output logic             rx_channel_choice_o,
    output logic             amp_ch_on_o,
    output logic             phase_ch_on_o,
    output logic             framing_ch_o,
    output logic      [2:0]  lowpass_setting_o,
    output logic             zero_select_a_o,
    output logic             zero_select_b_o,
    output logic             zero_select_c_o,
    output logic             zero_select_d_o,
    output logic             demod_iq_o,
    output logic             amd_mixer_o,
    output logic             squelch_active_o,
    output logic             squelch_ratio_o,
    output logic             agc_active_o,
    output logic             agc_reset_alg_o,
    output logic             gain_control_ratio_o
);
    logic [7:0] filt_ch_q;
    logic [7:0] demod_gain_q;
    logic [7:0] sq_time_q;
    logic [7:0] status;
    logic [7:0] rd_data;
    logic       wr_stb;
    logic [5:0] idx;
    logic [7:0] wr_data;
    logic       sq_active;
    logic       sq_active_q;
    logic       amp_on_q;
    logic       phase_on_q;
    logic       framing_q;
    logic       agc_active_q;
    logic       rx_active_q;
    logic [3:0] pulse_cnt_q;
    logic       agc_window;

    function automatic logic [7:0] read_mux(input logic [5:0] i,
                                            input logic [7:0] r1,
                                            input logic [7:0] r2,
                                            input logic [7:0] r3,
                                            input logic [7:0] st);
        case (i)
            `RCFG_IDX_FILT_CH:    read_mux = r1;
            `RCFG_IDX_DEMOD_GAIN: read_mux = r2;
            `RCFG_IDX_SQ_TIME:    read_mux = r3;
            `RCFG_IDX_STATUS:     read_mux = st;
            default:              read_mux = 8'h00;
        endcase
    endfunction : read_mux

    rcfg_wb_slave u_wb (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .wb_cyc_i  (wb_cyc_i),
        .wb_stb_i  (wb_stb_i),
        .wb_we_i   (wb_we_i),
        .wb_adr_i  (wb_adr_i),
        .wb_sel_i  (wb_sel_i),
        .wb_dat_i  (wb_dat_i),
        .rd_data_i (rd_data),
        .wb_ack_o  (wb_ack_o),
        .wb_dat_o  (wb_dat_o),
        .wr_stb_o  (wr_stb),
        .idx_o     (idx),
        .wr_data_o (wr_data)
    );

    // reads have no side effects; status is live state
    assign rd_data = read_mux(idx, filt_ch_q, demod_gain_q, sq_time_q, status);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_ch_q <= `RCFG_RST_FILT_CH;
        end else if (wr_stb && idx == `RCFG_IDX_FILT_CH) begin
            filt_ch_q <= wr_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            demod_gain_q <= `RCFG_RST_DEMOD_GAIN;
        end else if (wr_stb && idx == `RCFG_IDX_DEMOD_GAIN) begin
            demod_gain_q <= wr_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sq_time_q <= `RCFG_RST_SQ_TIME;
        end else if (wr_stb && idx == `RCFG_IDX_SQ_TIME) begin
            sq_time_q <= wr_data;
        end
    end

    // analogue settings leave straight from the register bits
    assign rx_channel_choice_o  = filt_ch_q[`RCFG_RX_CHANNEL_CHOICE_BIT];
    assign lowpass_setting_o    = filt_ch_q[`RCFG_LP_HI:`RCFG_LP_LO];
    assign zero_select_a_o      = filt_ch_q[`RCFG_ZA_BIT];
    assign zero_select_b_o      = filt_ch_q[`RCFG_ZB_BIT];
    assign zero_select_c_o      = filt_ch_q[`RCFG_ZC_BIT];
    assign zero_select_d_o      = filt_ch_q[`RCFG_ZD_BIT];
    assign demod_iq_o           = demod_gain_q[`RCFG_DEMOD_BIT];
    // iq without the mixer is software's error; flagged, not overridden
    assign amd_mixer_o          = demod_gain_q[`RCFG_AMD_BIT];
    assign squelch_ratio_o      = demod_gain_q[`RCFG_SQ_RATIO_BIT];
    assign agc_reset_alg_o      = demod_gain_q[`RCFG_AGC_ALG_BIT];
    assign gain_control_ratio_o = demod_gain_q[`RCFG_AGC_RATIO_BIT];

    // channel routing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amp_on_q   <= 1'b0;
            phase_on_q <= 1'b0;
            framing_q  <= 1'b0;
        end else if (ce_i) begin
            if (rx_single_ch_i) begin
                amp_on_q   <= ~filt_ch_q[`RCFG_RX_CHANNEL_CHOICE_BIT];
                phase_on_q <= filt_ch_q[`RCFG_RX_CHANNEL_CHOICE_BIT];
                framing_q  <= filt_ch_q[`RCFG_RX_CHANNEL_CHOICE_BIT];
            end else begin
                amp_on_q   <= 1'b1;
                phase_on_q <= 1'b1;
                framing_q  <= rx_manual_sel_i ? filt_ch_q[`RCFG_RX_CHANNEL_CHOICE_BIT]
                                              : rx_auto_ch_i;
            end
        end
    end

    assign amp_ch_on_o   = amp_on_q;
    assign phase_ch_on_o = phase_on_q;
    assign framing_ch_o  = framing_q;

    rcfg_squelch #(
        .DELAY_CYC (SQ_DELAY_CYC)
    ) u_sq (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .sq_dyn_i    (demod_gain_q[`RCFG_SQ_DYN_BIT]),
        .tx_end_i    (tx_end_i),
        .mrt_count_i (mrt_count_i),
        .sq_time_i   (sq_time_q),
        .sq_active_o (sq_active)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sq_active_q <= 1'b0;
        end else if (ce_i) begin
            sq_active_q <= sq_active;
        end
    end

    assign squelch_active_o = sq_active_q;

    // subcarrier pulse count restarts at each reception; saturates
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_active_q <= 1'b0;
            pulse_cnt_q <= 4'h0;
        end else if (ce_i) begin
            rx_active_q <= rx_active_i;
            if (!rx_active_i) begin
                pulse_cnt_q <= 4'h0;
            end else if (subcarrier_pulse_i && pulse_cnt_q != 4'(AGC_PULSES)) begin
                pulse_cnt_q <= pulse_cnt_q + 4'h1;
            end
        end
    end

    // the eighth pulse itself still sees the gain loop running
    assign agc_window = demod_gain_q[`RCFG_AGC_MODE_BIT]
                      || pulse_cnt_q < 4'(AGC_PULSES);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            agc_active_q <= 1'b0;
        end else if (ce_i) begin
            agc_active_q <= demod_gain_q[`RCFG_AGC_EN_BIT] && rx_active_i && agc_window;
        end
    end

    assign agc_active_o = agc_active_q;

    always_comb begin
        status = 8'h00;
        status[`RCFG_ST_SQ_BIT]     = sq_active_q;
        status[`RCFG_ST_AGC_BIT]    = agc_active_q;
        status[`RCFG_ST_FRAME_BIT]  = framing_q;
        status[`RCFG_ST_IQ_ERR_BIT] = demod_gain_q[`RCFG_DEMOD_BIT]
                                    & ~demod_gain_q[`RCFG_AMD_BIT];
    end

    property p_ch_single;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && rx_single_ch_i |=> phase_ch_on_o == $past(filt_ch_q[7])
                                   && amp_ch_on_o != phase_ch_on_o;
    endproperty
    a_ch_single: assert property (p_ch_single) else $error("single channel wrong");

    property p_ch_manual;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !rx_single_ch_i && rx_manual_sel_i
            |=> framing_ch_o == $past(filt_ch_q[7]) && amp_ch_on_o && phase_ch_on_o;
    endproperty
    a_ch_manual: assert property (p_ch_manual) else $error("manual framing wrong");

    property p_lp;
        @(posedge clk_i) disable iff (rst_i)
        wr_stb && idx == `RCFG_IDX_FILT_CH
            |=> lowpass_setting_o == $past(wr_data[6:4])
                && {zero_select_a_o, zero_select_b_o, zero_select_c_o, zero_select_d_o}
                   == $past(wr_data[3:0]);
    endproperty
    a_lp: assert property (p_lp) else $error("filter fields not applied");

    property p_demod;
        @(posedge clk_i) disable iff (rst_i)
        wr_stb && idx == `RCFG_IDX_DEMOD_GAIN
            |=> demod_iq_o == $past(wr_data[7]) && amd_mixer_o == $past(wr_data[6])
                && squelch_ratio_o == $past(wr_data[4]);
    endproperty
    a_demod: assert property (p_demod) else $error("demod fields not applied");

    property p_iq_flag;
        @(posedge clk_i) disable iff (rst_i)
        demod_iq_o && !amd_mixer_o |-> status[`RCFG_ST_IQ_ERR_BIT];
    endproperty
    a_iq_flag: assert property (p_iq_flag) else $error("iq without mixer unflagged");

    sequence s_pulses_done;
        rx_active_i && pulse_cnt_q == 4'(AGC_PULSES) && ce_i;
    endsequence

    property p_agc_first;
        @(posedge clk_i) disable iff (rst_i)
        s_pulses_done ##0 !demod_gain_q[2] |=> !agc_active_o;
    endproperty
    a_agc_first: assert property (p_agc_first) else $error("gain loop past window");

    property p_agc_full;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && rx_active_i && demod_gain_q[3] && demod_gain_q[2] |=> agc_active_o;
    endproperty
    a_agc_full: assert property (p_agc_full) else $error("gain loop not running");

    property p_agc_ctrl;
        @(posedge clk_i) disable iff (rst_i)
        agc_reset_alg_o == demod_gain_q[1] && gain_control_ratio_o == demod_gain_q[0]
            && (agc_active_o -> $past(demod_gain_q[3]));
    endproperty
    a_agc_ctrl: assert property (p_agc_ctrl) else $error("gain controls wrong");

    property p_sq_follow;
        @(posedge clk_i) disable iff (rst_i)
        ce_i |=> squelch_active_o == $past(sq_active);
    endproperty
    a_sq_follow: assert property (p_sq_follow) else $error("squelch output lag wrong");

    property p_readback;
        @(posedge clk_i) disable iff (rst_i)
        $rose(wb_ack_o) && !wb_we_i && wb_adr_i[7:2] == `RCFG_IDX_DEMOD_GAIN
            |-> wb_dat_o == {24'h00_0000, demod_gain_q};
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o && ce_i |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

    property p_ce_hold;
        @(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(filt_ch_q) && $stable(demod_gain_q) && $stable(agc_active_o)
                  && $stable(framing_ch_o) && $stable(squelch_active_o);
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("state moved while frozen");
endmodule : rcfg_regs

// ### rcfg_squelch.sv
// dynamic squelch sequencer: delay after transmit, stop on mask timer
// assumes tx_end_i is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`include "rcfg_defs.svh"
module rcfg_squelch
    import rcfg_pkg::*;
#(
    parameter int DELAY_CYC = `RCFG_SQ_DELAY_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       sq_dyn_i,
    input  wire logic       tx_end_i,
    input  wire logic [7:0] mrt_count_i,
    input  wire logic [7:0] sq_time_i,
    output logic            sq_active_o
);
    rcfg_sq_state_t state_q;
    logic [12:0]    cnt_q;
    logic           done;

    assign done = (mrt_count_i >= sq_time_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= RCFG_SQ_IDLE;
            cnt_q   <= 13'h0000;
        end else if (ce_i) begin
            case (state_q)
                RCFG_SQ_IDLE: begin
                    cnt_q <= 13'h0000;
                    if (sq_dyn_i && tx_end_i) begin
                        state_q <= RCFG_SQ_WAIT;
                    end
                end
                RCFG_SQ_WAIT: begin
                    cnt_q <= cnt_q + 13'h0001;
                    if (!sq_dyn_i) begin
                        state_q <= RCFG_SQ_IDLE;
                    end else if (cnt_q == 13'(DELAY_CYC - 1)) begin
                        state_q <= RCFG_SQ_ACT;
                    end
                end
                RCFG_SQ_ACT: begin
                    if (!sq_dyn_i || done) begin
                        state_q <= RCFG_SQ_IDLE;
                    end
                end
                default: state_q <= RCFG_SQ_IDLE;
            endcase
        end
    end

    assign sq_active_o = (state_q == RCFG_SQ_ACT);

    sequence s_armed;
        state_q == RCFG_SQ_IDLE && sq_dyn_i && tx_end_i && ce_i;
    endsequence

    property p_sq_arm;
        @(posedge clk_i) disable iff (rst_i)
        s_armed |=> state_q == RCFG_SQ_WAIT && cnt_q == 13'h0000;
    endproperty
    a_sq_arm: assert property (p_sq_arm) else $error("squelch not armed");

    property p_sq_delay;
        @(posedge clk_i) disable iff (rst_i)
        $rose(sq_active_o) |-> $past(cnt_q) == 13'(DELAY_CYC - 1);
    endproperty
    a_sq_delay: assert property (p_sq_delay) else $error("squelch delay wrong");

    property p_sq_end;
        @(posedge clk_i) disable iff (rst_i)
        sq_active_o && done && ce_i |=> !sq_active_o;
    endproperty
    a_sq_end: assert property (p_sq_end) else $error("squelch did not stop");

    property p_sq_off;
        @(posedge clk_i) disable iff (rst_i)
        !sq_dyn_i && ce_i |=> state_q != RCFG_SQ_ACT;
    endproperty
    a_sq_off: assert property (p_sq_off) else $error("squelch while disabled");
endmodule : rcfg_squelch

// ### rcfg_wb_slave.sv
// classic wishbone slave front end for the configuration bank
// assumes a single-cycle master that holds its request until ack
`timescale 1ns/1ps
module rcfg_wb_slave
    import rcfg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [7:0]  rd_data_i,
    output logic             wb_ack_o,
    output logic      [31:0] wb_dat_o,
    output logic             wr_stb_o,
    output logic      [5:0]  idx_o,
    output logic      [7:0]  wr_data_o
);
    logic        ack_q;
    logic [31:0] dat_q;
    logic        req;

    assign req       = wb_cyc_i & wb_stb_i;
    assign idx_o     = wb_adr_i[7:2];
    assign wr_data_o = wb_dat_i[7:0];
    // the write lands on the edge where the master sees ack
    assign wr_stb_o  = ce_i & req & wb_we_i & ack_q & wb_sel_i[0];

    // one idle cycle, then ack for exactly one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= req & ~ack_q;
        end
    end

    // unmapped indices read zero; upper lanes always zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (ce_i && req && !ack_q) begin
            dat_q <= wb_we_i ? 32'h0000_0000 : {24'h00_0000, rd_data_i};
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
endmodule : rcfg_wb_slave

// ### testbench.sv
// self-checking bench for the receiver configuration bank
// assumes rcfg_regs on one 200 MHz clock, driven by a classic wishbone master
`timescale 1ns/1ps
`include "rcfg_defs.svh"
module testbench;
    import rcfg_pkg::*;
    // short squelch delay keeps the run brief; expectations derive from it
    localparam int         DLY    = 20;
    localparam logic [7:0] ADR_R1 = {`RCFG_IDX_FILT_CH, 2'b00};
    localparam logic [7:0] ADR_R2 = {`RCFG_IDX_DEMOD_GAIN, 2'b00};
    localparam logic [7:0] ADR_SQ = {`RCFG_IDX_SQ_TIME, 2'b00};
    localparam logic [7:0] ADR_ST = {`RCFG_IDX_STATUS, 2'b00};

    logic        clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i, mrt_count_i, v1, v2;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, d;
    logic        rx_single_ch_i, rx_manual_sel_i, rx_auto_ch_i, tx_end_i;
    logic        rx_active_i, subcarrier_pulse_i, rx_channel_choice_o;
    logic        amp_ch_on_o, phase_ch_on_o, framing_ch_o, seen;
    logic [2:0]  lowpass_setting_o;
    logic        zero_select_a_o, zero_select_b_o, zero_select_c_o, zero_select_d_o;
    logic        demod_iq_o, amd_mixer_o, squelch_active_o, squelch_ratio_o;
    logic        agc_active_o, agc_reset_alg_o, gain_control_ratio_o;
    int          failures, n_tests, k, seed;

    rcfg_regs #(.SQ_DELAY_CYC(DLY)) rcfg_regs_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .rx_single_ch_i(rx_single_ch_i),
        .rx_manual_sel_i(rx_manual_sel_i), .rx_auto_ch_i(rx_auto_ch_i),
        .tx_end_i(tx_end_i), .rx_active_i(rx_active_i),
        .subcarrier_pulse_i(subcarrier_pulse_i), .mrt_count_i(mrt_count_i),
        .rx_channel_choice_o(rx_channel_choice_o), .amp_ch_on_o(amp_ch_on_o),
        .phase_ch_on_o(phase_ch_on_o), .framing_ch_o(framing_ch_o),
        .lowpass_setting_o(lowpass_setting_o), .zero_select_a_o(zero_select_a_o),
        .zero_select_b_o(zero_select_b_o), .zero_select_c_o(zero_select_c_o),
        .zero_select_d_o(zero_select_d_o), .demod_iq_o(demod_iq_o),
        .amd_mixer_o(amd_mixer_o), .squelch_active_o(squelch_active_o),
        .squelch_ratio_o(squelch_ratio_o), .agc_active_o(agc_active_o),
        .agc_reset_alg_o(agc_reset_alg_o), .gain_control_ratio_o(gain_control_ratio_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // request held until ack is sampled high; released at that same edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wd;
        // no cycle count assumed: a hung slave is ended by the watchdog
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        chk("ack", 32'h1, 32'(wb_ack_o));
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] adr, input logic [7:0] v);
        logic [31:0] r;
        wb(1'b1, adr, 4'h1, {24'h0, v}, r);
    endtask : wr

    task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp, input string name);
        logic [31:0] r;
        wb(1'b0, adr, 4'hF, 32'h0, r);
        chk(name, {24'h0, exp}, r);
    endtask : rdchk

    task automatic pulse_tx();
        @(posedge clk_i);
        tx_end_i <= 1'b1;
        @(posedge clk_i);
        tx_end_i <= 1'b0;
    endtask : pulse_tx

    function automatic logic [2:0] exp_route(input logic s, input logic m,
                                             input logic a, input logic b);
        if (s) begin
            return {~b, b, b};
        end
        return {2'b11, m ? b : a};
    endfunction : exp_route

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        report_and_stop();
    end

    initial begin
        {rst_i, ce_i} = 2'b11;
        {wb_cyc_i, wb_stb_i, wb_we_i, tx_end_i, rx_active_i, subcarrier_pulse_i} = '0;
        {rx_single_ch_i, rx_manual_sel_i, rx_auto_ch_i} = 3'b100;
        {wb_adr_i, wb_sel_i, wb_dat_i, mrt_count_i} = '0;
        failures = 0;
        n_tests = 0;
        seed = $urandom(32'h7F36);
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(ADR_R1, 8'h00, "reg1 reset");
        rdchk(ADR_R2, 8'h2C, "reg2 reset");
        repeat (24) begin
            v1 = 8'($urandom);
            v2 = 8'($urandom);
            v2[6] = v2[6] | v2[7];
            wr(ADR_R1, v1);
            wr(ADR_R2, v2);
            rdchk(ADR_R1, v1, "reg1");
            rdchk(ADR_R2, v2, "reg2");
            chk("filter fields", 32'(v1), 32'({rx_channel_choice_o, lowpass_setting_o,
                zero_select_a_o, zero_select_b_o, zero_select_c_o, zero_select_d_o}));
            chk("demod fields", 32'({v2[7:6], v2[4], v2[1:0]}), 32'({demod_iq_o, amd_mixer_o,
                squelch_ratio_o, agc_reset_alg_o, gain_control_ratio_o}));
        end
        // unmapped place and a write without its byte lane both leave reg1 alone
        wb(1'b1, 8'h80, 4'hF, 32'hFF, d);
        wb(1'b0, 8'h80, 4'hF, 32'h0, d);
        chk("unmapped read", 32'h0, d);
        wb(1'b1, ADR_R1, 4'h0, 32'h5A, d);
        rdchk(ADR_R1, v1, "reg1 after sel0 write");
        repeat (16) begin
            v1 = 8'($urandom);
            wr(ADR_R1, v1);
            @(posedge clk_i);
            rx_single_ch_i  <= 1'($urandom);
            rx_manual_sel_i <= 1'($urandom);
            rx_auto_ch_i    <= 1'($urandom);
            repeat (3) @(posedge clk_i);
            chk("routing", 32'(exp_route(rx_single_ch_i, rx_manual_sel_i, rx_auto_ch_i, v1[7])),
                32'({amp_ch_on_o, phase_ch_on_o, framing_ch_o}));
        end
        // clock enable low: routing must hold although its inputs move
        @(posedge clk_i);
        ce_i           <= 1'b0;
        rx_single_ch_i <= ~rx_single_ch_i;
        repeat (3) @(posedge clk_i);
        chk("frozen", 32'(exp_route(~rx_single_ch_i, rx_manual_sel_i, rx_auto_ch_i,
            v1[7])), 32'({amp_ch_on_o, phase_ch_on_o, framing_ch_o}));
        ce_i <= 1'b1;
        wr(ADR_SQ, 8'h10);
        wr(ADR_R2, 8'h20);
        pulse_tx();
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (squelch_active_o !== 1'b1 && k < DLY + 10);
        // delay counted from the edge after tx_end is taken, plus the output flop
        chk("squelch delay", 32'(DLY + 2), 32'(k));
        wb(1'b0, ADR_ST, 4'hF, 32'h0, d);
        chk("status squelch", 32'h1, 32'(d[`RCFG_ST_SQ_BIT]));
        @(posedge clk_i);
        mrt_count_i <= 8'h10;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (squelch_active_o !== 1'b0 && k < 10);
        chk("squelch end", 32'h3, 32'(k));
        mrt_count_i <= 8'h00;
        wr(ADR_R2, 8'h80);
        wb(1'b0, ADR_ST, 4'hF, 32'h0, d);
        chk("iq without mixer", 32'h1, 32'(d[`RCFG_ST_IQ_ERR_BIT]));
        wr(ADR_R2, 8'h00);
        pulse_tx();
        seen = 1'b0;
        repeat (DLY + 10) begin
            @(posedge clk_i);
            seen = seen | squelch_active_o;
        end
        chk("squelch disabled", 32'h0, 32'(seen));
        for (int m = 0; m < 2; m++) begin
            wr(ADR_R2, (m == 1) ? 8'h0C : 8'h08);
            @(posedge clk_i);
            rx_active_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            chk("agc start", 32'h1, 32'(agc_active_o));
            for (int i = 0; i < 8; i++) begin
                @(posedge clk_i);
                subcarrier_pulse_i <= 1'b1;
                @(posedge clk_i);
                subcarrier_pulse_i <= 1'b0;
                repeat ($urandom_range(0, 3)) @(posedge clk_i);
                if (i == 6) begin
                    chk("agc seven pulses", 32'h1, 32'(agc_active_o));
                end
            end
            repeat (3) @(posedge clk_i);
            chk("agc after eight", 32'(m), 32'(agc_active_o));
            rx_active_i <= 1'b0;
            repeat (3) @(posedge clk_i);
            chk("agc idle", 32'h0, 32'(agc_active_o));
        end
        // reset in mid-run: both registers return to their defaults
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(ADR_R1, `RCFG_RST_FILT_CH, "reg1 after reset");
        rdchk(ADR_R2, `RCFG_RST_DEMOD_GAIN, "reg2 after reset");
        report_and_stop();
    end
endmodule : testbench
